// ### src/rsi_regs.svh
/*
 * constants of the reset state initialiser: reset values, field positions,
 * port offsets and timing counts.
 * assumes inclusion from the design modules and the bench only.
 */
`ifndef RSI_REGS_SVH
`define RSI_REGS_SVH

// ****************************************************************
// clock
// ****************************************************************
`define RSI_CLK_PERIOD_NS        20

// ****************************************************************
// register offsets on the plain register port
// ****************************************************************
`define RSI_ADDR_STATUS          5'h00
`define RSI_ADDR_SYSTEM_MODE_REG            5'h01
`define RSI_ADDR_WATCHDOG_CONTROL_REG            5'h02
`define RSI_ADDR_TBC             5'h03
`define RSI_ADDR_INTC0           5'h04
`define RSI_ADDR_INTC1           5'h05
`define RSI_ADDR_INTC2           5'h06
`define RSI_ADDR_PA              5'h07
`define RSI_ADDR_PAC             5'h08
`define RSI_ADDR_PORT_A_PULLUP            5'h09
`define RSI_ADDR_PORT_A_WAKEUP            5'h0A
`define RSI_ADDR_MP0             5'h0B
`define RSI_ADDR_MP1             5'h0C
`define RSI_ADDR_ACC             5'h0D
`define RSI_ADDR_TABLE_POINTER            5'h0E
`define RSI_ADDR_TABLE_HIGH_BYTE            5'h0F
`define RSI_ADDR_PCL             5'h10
`define RSI_ADDR_EEA             5'h11
`define RSI_ADDR_SERIAL_IFACE_CTRL0           5'h12
`define RSI_ADDR_SERIAL_IFACE_CTRL1           5'h13
`define RSI_ADDR_ACERL           5'h14
`define RSI_ADDR_TMBASE          5'h18
`define RSI_NUM_TM               8

// ****************************************************************
// status fields
// ****************************************************************
`define RSI_STAT_PDF_BIT         4
`define RSI_STAT_TO_BIT          5

// ****************************************************************
// reset values
// ****************************************************************
`define RSI_RST_SYSTEM_MODE_REG             8'h03
`define RSI_RST_WATCHDOG_CONTROL_REG             8'h7A
`define RSI_RST_TBC              8'h37
`define RSI_RST_SERIAL_IFACE_CTRL0            8'hE0
`define RSI_RST_SERIAL_IFACE_CTRL1            8'h81
`define RSI_RST_ONES             8'hFF
`define RSI_RST_ZERO             8'h00
`define RSI_RST_MP_MSB           8'h80
`define RSI_RST_EEA              5'h00
`define RSI_RST_TOP_STACK        4'hF
`define RSI_SERIAL_IFACE_CTRL0_MASK           8'hFE
`define RSI_INTC0_MASK           8'h7F

`endif

// ### src/rsi_pkg.sv
/*
 * types of the reset state initialiser.
 * assumes nothing beyond the constants header.
 */
package rsi_pkg;
	typedef enum logic [2:0] {
		RSI_NONE,
		RSI_POWERON,
		RSI_PINLV,
		RSI_WDT_RUN,
		RSI_WDT_LOWPWR
	} rsi_cause_e;

	typedef logic [7:0] rsi_byte_t;
endpackage

// ### src/rsi_cause_arb.sv
/*
 * picks the reset cause of this cycle from the reset sources and the
 * power mode, power-on first, then pin or low voltage, then watchdog.
 * assumes all sources are one-cycle pulses synchronous to mclk.
 */
`timescale 1ns/1ps
`include "rsi_regs.svh"

module rsi_cause_arb
	import rsi_pkg::*;
(
	// sources
	input  wire logic       powerOnRst,
	input  wire logic       externalClearPin,
	input  wire logic       lowVoltageReset,
	input  wire logic       watchdogTimeout,
	// mode
	input  wire logic       lowPowerMode,
	// cause
	output rsi_cause_e      cause
);
	always_comb begin
		if (powerOnRst) begin
			cause = RSI_POWERON;
		end else if (externalClearPin || lowVoltageReset) begin
			cause = RSI_PINLV;
		end else if (watchdogTimeout) begin
			cause = lowPowerMode ? RSI_WDT_LOWPWR : RSI_WDT_RUN;
		end else begin
			cause = RSI_NONE;
		end
	end
endmodule // rsi_cause_arb

// ### src/rsi_wdt_counter.sv
/*
 * watchdog counter, cleared by the clear pulse (any reset load or clear instruction) and counting otherwise.
 * assumes clear is a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "rsi_regs.svh"

module rsi_wdt_counter #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             resetn,
	// control
	input  wire logic             clear,
	// count
	output logic [WIDTH-1:0]      count
);
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else begin
			count <= count + WIDTH'(1);
		end
	end
endmodule // rsi_wdt_counter

// ### src/rsi_reset_init.sv
/*
 * reset state initialiser: loads per-cause reset values into the core,
 * interrupt, port, watchdog, timebase, serial and timer registers and
 * keeps the timeout and powerdown flags.
 * assumes reset sources are single-cycle pulses synchronous to mclk and
 * a plain register port driven by a master on mclk.
 */
// Our own choices: the address map and the strobed register port.
// Summary of operation
// - status holds timeout and powerdown flags, set by resets and low-power entry
// - power-on reset clears timeout and powerdown flags
// - pin or low-voltage reset in normal/slow keeps both flags
// - watchdog reset in normal/slow sets timeout, keeps powerdown
// - watchdog reset in idle/sleep sets timeout and powerdown
// - power-on reset zeroes program counter, stack pointer to top of stack
// - power-on reset clears all interrupt enables
// - power-on reset clears watchdog counter, which then counts at once
// - power-on reset switches timer modules off
// - power-on reset makes all port pins inputs, analog pins converter inputs
// - all but idle watchdog reset: port data/direction ones, pullup/wakeup zeros
// - all but idle watchdog reset load mode, watchdog and timebase control
// - idle watchdog reset clears program counter low and eeprom address
// - pin, low-voltage, run watchdog keep accumulator and table registers
// - every reset forces pointer register top bits to one
// - all but idle watchdog reset init serial controls, clear timer regs
// - idle watchdog reset keeps state but zeroes counter, stack pointer, program counter low and eeprom address, sets pointer top bits
`timescale 1ns/1ps
`include "rsi_regs.svh"

module rsi_reset_init
	import rsi_pkg::*;
#(
	parameter int WDT_WIDTH = 16
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              resetn,
	// reset sources, one-cycle pulses
	input  wire logic              powerOnRst,
	input  wire logic              externalClearPin,
	input  wire logic              lowVoltageReset,
	input  wire logic              watchdogTimeout,
	// power mode
	input  wire logic              lowPowerMode,
	input  wire logic              enterLowPower,
	input  wire logic              clearWdtInstr,
	// register port
	input  wire logic [4:0]        regAddr,
	input  wire logic [7:0]        regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic [7:0]             regRdata,
	// core state
	output logic [7:0]             programCounterLow_r,
	output logic [3:0]             stackPointer_r,
	output logic                   timeoutFlag_r,
	output logic                   powerdownFlag_r,
	output logic [7:0]             portADirection_r,
	output logic [7:0]             analogInputs_r,
	output logic [WDT_WIDTH-1:0]   watchdogCount_r
);
	// ****************************************************************
	// cause selection
	// ****************************************************************
	rsi_cause_e cause;
	logic       fullRst;
	logic       wdtIdle;
	logic       anyRst;

	rsi_cause_arb uArb (
		.powerOnRst       (powerOnRst),
		.externalClearPin (externalClearPin),
		.lowVoltageReset  (lowVoltageReset),
		.watchdogTimeout  (watchdogTimeout),
		.lowPowerMode     (lowPowerMode),
		.cause            (cause)
	);

	assign fullRst = (cause == RSI_POWERON) || (cause == RSI_PINLV) || (cause == RSI_WDT_RUN);
	assign wdtIdle = (cause == RSI_WDT_LOWPWR);
	assign anyRst  = fullRst || wdtIdle;

	// ****************************************************************
	// register storage
	// ****************************************************************
	rsi_byte_t systemModeReg_r, watchdogControlReg_r, timebaseControlReg_r;
	rsi_byte_t intc0_r, intc1_r, intc2_r;
	rsi_byte_t portA_r, portAPullup_r, portAWakeup_r;
	rsi_byte_t memoryPointer0_r, memoryPointer1_r, acc_r, tablePointer_r;
	rsi_byte_t serialIfaceCtrl0_r, serialIfaceCtrl1_r;
	logic [5:0] tableHighByte_r;
	logic [4:0] eepromAddressReg_r;
	rsi_byte_t timerReg_r [`RSI_NUM_TM];
	logic       wdtClear;

	// flags
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			timeoutFlag_r   <= 1'b0;
			powerdownFlag_r <= 1'b0;
		end else begin
			unique case (cause)
				RSI_POWERON: begin
					timeoutFlag_r   <= 1'b0;
					powerdownFlag_r <= 1'b0;
				end
				RSI_PINLV: begin
				end
				RSI_WDT_RUN: begin
					timeoutFlag_r <= 1'b1;
				end
				RSI_WDT_LOWPWR: begin
					timeoutFlag_r   <= 1'b1;
					powerdownFlag_r <= 1'b1;
				end
				RSI_NONE: begin
					if (enterLowPower) begin
						timeoutFlag_r   <= 1'b0;
						powerdownFlag_r <= 1'b1;
					end else if (clearWdtInstr) begin
						timeoutFlag_r   <= 1'b0;
						powerdownFlag_r <= 1'b0;
					end
				end
			endcase
		end
	end

	// program counter low and stack pointer
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			programCounterLow_r <= `RSI_RST_ZERO;
			stackPointer_r      <= `RSI_RST_TOP_STACK;
		end else if (anyRst) begin
			programCounterLow_r <= `RSI_RST_ZERO;
			stackPointer_r      <= wdtIdle ? 4'h0 : `RSI_RST_TOP_STACK;
		end else if (regWr && regAddr == `RSI_ADDR_PCL) begin
			programCounterLow_r <= regWdata;
		end
	end

	// mode, watchdog and timebase control
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			systemModeReg_r      <= `RSI_RST_SYSTEM_MODE_REG;
			watchdogControlReg_r <= `RSI_RST_WATCHDOG_CONTROL_REG;
			timebaseControlReg_r <= `RSI_RST_TBC;
		end else if (fullRst) begin
			systemModeReg_r      <= `RSI_RST_SYSTEM_MODE_REG;
			watchdogControlReg_r <= `RSI_RST_WATCHDOG_CONTROL_REG;
			timebaseControlReg_r <= `RSI_RST_TBC;
		end else if (regWr) begin
			if (regAddr == `RSI_ADDR_SYSTEM_MODE_REG) systemModeReg_r <= regWdata;
			if (regAddr == `RSI_ADDR_WATCHDOG_CONTROL_REG) watchdogControlReg_r <= regWdata;
			if (regAddr == `RSI_ADDR_TBC) timebaseControlReg_r <= regWdata;
		end
	end

	// interrupt control
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			intc0_r <= `RSI_RST_ZERO;
			intc1_r <= `RSI_RST_ZERO;
			intc2_r <= `RSI_RST_ZERO;
		end else if (fullRst) begin
			intc0_r <= `RSI_RST_ZERO;
			intc1_r <= `RSI_RST_ZERO;
			intc2_r <= `RSI_RST_ZERO;
		end else if (regWr) begin
			if (regAddr == `RSI_ADDR_INTC0) intc0_r <= regWdata & `RSI_INTC0_MASK;
			if (regAddr == `RSI_ADDR_INTC1) intc1_r <= regWdata;
			if (regAddr == `RSI_ADDR_INTC2) intc2_r <= regWdata;
		end
	end

	// port a and analog selection
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			portA_r          <= `RSI_RST_ONES;
			portADirection_r <= `RSI_RST_ONES;
			portAPullup_r    <= `RSI_RST_ZERO;
			portAWakeup_r    <= `RSI_RST_ZERO;
			analogInputs_r   <= `RSI_RST_ONES;
		end else if (fullRst) begin
			portA_r          <= `RSI_RST_ONES;
			portADirection_r <= `RSI_RST_ONES;
			portAPullup_r    <= `RSI_RST_ZERO;
			portAWakeup_r    <= `RSI_RST_ZERO;
			analogInputs_r   <= `RSI_RST_ONES;
		end else if (regWr) begin
			if (regAddr == `RSI_ADDR_PA) portA_r <= regWdata;
			if (regAddr == `RSI_ADDR_PAC) portADirection_r <= regWdata;
			if (regAddr == `RSI_ADDR_PORT_A_PULLUP) portAPullup_r <= regWdata;
			if (regAddr == `RSI_ADDR_PORT_A_WAKEUP) portAWakeup_r <= regWdata;
			if (regAddr == `RSI_ADDR_ACERL) analogInputs_r <= regWdata;
		end
	end

	// memory pointers: top bit forced on every reset, rest kept
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			memoryPointer0_r <= `RSI_RST_MP_MSB;
			memoryPointer1_r <= `RSI_RST_MP_MSB;
		end else if (anyRst) begin
			memoryPointer0_r <= memoryPointer0_r | `RSI_RST_MP_MSB;
			memoryPointer1_r <= memoryPointer1_r | `RSI_RST_MP_MSB;
		end else if (regWr) begin
			if (regAddr == `RSI_ADDR_MP0) memoryPointer0_r <= regWdata;
			if (regAddr == `RSI_ADDR_MP1) memoryPointer1_r <= regWdata;
		end
	end

	// accumulator and table registers, cleared only by resetn, kept by every reset
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			acc_r           <= `RSI_RST_ZERO;
			tablePointer_r  <= `RSI_RST_ZERO;
			tableHighByte_r <= 6'h00;
		end else if (anyRst) begin
			// kept on every reset, power-on included
		end else if (regWr) begin
			if (regAddr == `RSI_ADDR_ACC) acc_r <= regWdata;
			if (regAddr == `RSI_ADDR_TABLE_POINTER) tablePointer_r <= regWdata;
			if (regAddr == `RSI_ADDR_TABLE_HIGH_BYTE) tableHighByte_r <= regWdata[5:0];
		end
	end

	// eeprom address
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			eepromAddressReg_r <= `RSI_RST_EEA;
		end else if (wdtIdle) begin
			eepromAddressReg_r <= `RSI_RST_EEA;
		end else if (regWr && regAddr == `RSI_ADDR_EEA) begin
			eepromAddressReg_r <= regWdata[4:0];
		end
	end

	// serial interface control
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			serialIfaceCtrl0_r <= `RSI_RST_SERIAL_IFACE_CTRL0;
			serialIfaceCtrl1_r <= `RSI_RST_SERIAL_IFACE_CTRL1;
		end else if (fullRst) begin
			serialIfaceCtrl0_r <= `RSI_RST_SERIAL_IFACE_CTRL0;
			serialIfaceCtrl1_r <= `RSI_RST_SERIAL_IFACE_CTRL1;
		end else if (regWr) begin
			if (regAddr == `RSI_ADDR_SERIAL_IFACE_CTRL0) serialIfaceCtrl0_r <= regWdata & `RSI_SERIAL_IFACE_CTRL0_MASK;
			if (regAddr == `RSI_ADDR_SERIAL_IFACE_CTRL1) serialIfaceCtrl1_r <= regWdata;
		end
	end

	// timer control and compare registers
	genvar gi;
	generate
		for (gi = 0; gi < `RSI_NUM_TM; gi++) begin : gTimer
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					timerReg_r[gi] <= `RSI_RST_ZERO;
				end else if (fullRst) begin
					timerReg_r[gi] <= `RSI_RST_ZERO;
				end else if (regWr && regAddr == (`RSI_ADDR_TMBASE + 5'(gi))) begin
					timerReg_r[gi] <= regWdata;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// watchdog counter
	// ****************************************************************
	assign wdtClear = anyRst || clearWdtInstr;

	rsi_wdt_counter #(.WIDTH(WDT_WIDTH)) uWdt (
		.mclk   (mclk),
		.resetn (resetn),
		.clear  (wdtClear),
		.count  (watchdogCount_r)
	);

	// ****************************************************************
	// read port
	// ****************************************************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			regRdata <= `RSI_RST_ZERO;
		end else if (regRd) begin
			regRdata <= `RSI_RST_ZERO;
			if (regAddr >= `RSI_ADDR_TMBASE) begin
				regRdata <= timerReg_r[3'(regAddr - `RSI_ADDR_TMBASE)];
			end else begin
				case (regAddr)
					`RSI_ADDR_STATUS: regRdata <= {2'b00, timeoutFlag_r, powerdownFlag_r, 4'h0};
					`RSI_ADDR_SYSTEM_MODE_REG:   regRdata <= systemModeReg_r;
					`RSI_ADDR_WATCHDOG_CONTROL_REG:   regRdata <= watchdogControlReg_r;
					`RSI_ADDR_TBC:    regRdata <= timebaseControlReg_r;
					`RSI_ADDR_INTC0:  regRdata <= intc0_r;
					`RSI_ADDR_INTC1:  regRdata <= intc1_r;
					`RSI_ADDR_INTC2:  regRdata <= intc2_r;
					`RSI_ADDR_PA:     regRdata <= portA_r;
					`RSI_ADDR_PAC:    regRdata <= portADirection_r;
					`RSI_ADDR_PORT_A_PULLUP:   regRdata <= portAPullup_r;
					`RSI_ADDR_PORT_A_WAKEUP:   regRdata <= portAWakeup_r;
					`RSI_ADDR_MP0:    regRdata <= memoryPointer0_r;
					`RSI_ADDR_MP1:    regRdata <= memoryPointer1_r;
					`RSI_ADDR_ACC:    regRdata <= acc_r;
					`RSI_ADDR_TABLE_POINTER:   regRdata <= tablePointer_r;
					`RSI_ADDR_TABLE_HIGH_BYTE:   regRdata <= {2'b00, tableHighByte_r};
					`RSI_ADDR_PCL:    regRdata <= programCounterLow_r;
					`RSI_ADDR_EEA:    regRdata <= {3'b000, eepromAddressReg_r};
					`RSI_ADDR_SERIAL_IFACE_CTRL0:  regRdata <= serialIfaceCtrl0_r;
					`RSI_ADDR_SERIAL_IFACE_CTRL1:  regRdata <= serialIfaceCtrl1_r;
					`RSI_ADDR_ACERL:  regRdata <= analogInputs_r;
					default:          regRdata <= `RSI_RST_ZERO;
				endcase
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	flag_poweron_a: assert property (@(posedge mclk) disable iff (!resetn)
		powerOnRst |=> !timeoutFlag_r && !powerdownFlag_r)
		else $error("flags not cleared by power-on reset");
	flag_pinkeep_a: assert property (@(posedge mclk) disable iff (!resetn)
		(cause == RSI_PINLV) |=> $stable(timeoutFlag_r) && $stable(powerdownFlag_r))
		else $error("flags changed by pin reset");
	flag_wdtrun_a: assert property (@(posedge mclk) disable iff (!resetn)
		(cause == RSI_WDT_RUN) |=> timeoutFlag_r && $stable(powerdownFlag_r))
		else $error("run watchdog flags wrong");
	flag_wdtidle_a: assert property (@(posedge mclk) disable iff (!resetn)
		(cause == RSI_WDT_LOWPWR) |=> timeoutFlag_r && powerdownFlag_r)
		else $error("idle watchdog flags wrong");
	pc_stack_a: assert property (@(posedge mclk) disable iff (!resetn)
		powerOnRst |=> programCounterLow_r == 8'h00 && stackPointer_r == 4'hF)
		else $error("pc or stack not initialised");
	port_init_a: assert property (@(posedge mclk) disable iff (!resetn)
		fullRst |=> portADirection_r == 8'hFF && portAPullup_r == 8'h00)
		else $error("port registers not initialised");
	ctrl_init_a: assert property (@(posedge mclk) disable iff (!resetn)
		fullRst |=> systemModeReg_r == 8'h03 && watchdogControlReg_r == 8'h7A)
		else $error("mode or watchdog control not loaded");
	idle_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
		wdtIdle |=> eepromAddressReg_r == 5'h00 && $stable(systemModeReg_r))
		else $error("idle watchdog reset wrong");
	mp_msb_a: assert property (@(posedge mclk) disable iff (!resetn)
		anyRst |=> memoryPointer0_r[7] && memoryPointer1_r[7])
		else $error("pointer top bit not set");
	wdt_count_a: assert property (@(posedge mclk) disable iff (!resetn)
		(powerOnRst ##1 !wdtClear) |=> watchdogCount_r == WDT_WIDTH'(1))
		else $error("watchdog not counting after reset");
endmodule // rsi_reset_init

// ### bench/rsi_reset_init_tb.sv
/*
 * self-checking bench of the reset state initialiser: table rows per reset
 * cause, then hand-written reset, refusal, priority and bus cases.
 * assumes the design package and the constants header on the include path.
 */
`timescale 1ns/1ps
`include "rsi_regs.svh"

module rsi_reset_init_tb
	import rsi_pkg::*;
;
	// ****************************************************************
	// signals
	// ****************************************************************
	localparam logic [7:0] DIRTY = 8'h15;

	typedef struct packed {
		logic [4:0]      addr;
		logic [3:0][7:0] exp;
		logic [3:0]      care;
	} rsi_row_s;

	logic        mclk             = 1'b0;
	logic        resetn           = 1'b0;
	logic        powerOnRst       = 1'b0;
	logic        externalClearPin = 1'b0;
	logic        lowVoltageReset  = 1'b0;
	logic        watchdogTimeout  = 1'b0;
	logic        lowPowerMode     = 1'b0;
	logic        enterLowPower    = 1'b0;
	logic        clearWdtInstr    = 1'b0;
	logic [4:0]  regAddr          = 5'h00;
	logic [7:0]  regWdata         = 8'h00;
	logic        regWr            = 1'b0;
	logic        regRd            = 1'b0;
	logic [7:0]  regRdata;
	logic [7:0]  programCounterLow_r;
	logic [3:0]  stackPointer_r;
	logic        timeoutFlag_r;
	logic        powerdownFlag_r;
	logic [7:0]  portADirection_r;
	logic [7:0]  analogInputs_r;
	logic [15:0] watchdogCount_r;
	int          failCount        = 0;
	int          cmpCount         = 0;
	rsi_row_s    rows [$];
	logic [7:0]  rd;

	// cause order: power-on, pin, low voltage, watchdog run, watchdog idle
	logic [5:0]  causeMask [5] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h08};
	int          grp       [5] = '{0, 1, 1, 2, 3};
	logic        expTo     [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic        expPdf    [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
	logic        preLow    [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

	rsi_reset_init #(
		.WDT_WIDTH (16)
	) dut (
		.mclk                (mclk),
		.resetn              (resetn),
		.powerOnRst          (powerOnRst),
		.externalClearPin    (externalClearPin),
		.lowVoltageReset     (lowVoltageReset),
		.watchdogTimeout     (watchdogTimeout),
		.lowPowerMode        (lowPowerMode),
		.enterLowPower       (enterLowPower),
		.clearWdtInstr       (clearWdtInstr),
		.regAddr             (regAddr),
		.regWdata            (regWdata),
		.regWr               (regWr),
		.regRd               (regRd),
		.regRdata            (regRdata),
		.programCounterLow_r (programCounterLow_r),
		.stackPointer_r      (stackPointer_r),
		.timeoutFlag_r       (timeoutFlag_r),
		.powerdownFlag_r     (powerdownFlag_r),
		.portADirection_r    (portADirection_r),
		.analogInputs_r      (analogInputs_r),
		.watchdogCount_r     (watchdogCount_r)
	);

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			failCount++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wrReg(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	task automatic rdReg(input logic [4:0] a, output logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		d = regRdata;
	endtask

	// one-cycle pulse on {clear, lowpower entry, watchdog, lv, pin, power-on}
	task automatic pulse(input logic [5:0] m, input logic lp);
		@(posedge mclk);
		{clearWdtInstr, enterLowPower, watchdogTimeout, lowVoltageReset,
			externalClearPin, powerOnRst} <= m;
		lowPowerMode <= lp;
		@(posedge mclk);
		{clearWdtInstr, enterLowPower, watchdogTimeout, lowVoltageReset,
			externalClearPin, powerOnRst} <= 6'h00;
		@(negedge mclk);
	endtask

	task automatic addRow(input logic [4:0] a, input logic [7:0] f, input logic [7:0] i,
			input logic [3:0] c);
		rows.push_back('{a, {i, f, f, f}, c});
	endtask

	task automatic finalReport;
		$display("comparisons %0d mismatches %0d", cmpCount, failCount);
		if (failCount == 0 && cmpCount > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ****************************************************************
	// clock and watchdog
	// ****************************************************************
	initial begin
		forever #(`RSI_CLK_PERIOD_NS / 2) mclk = ~mclk;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		failCount++;
		finalReport();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		addRow(`RSI_ADDR_SYSTEM_MODE_REG, `RSI_RST_SYSTEM_MODE_REG, DIRTY, 4'hF);
		addRow(`RSI_ADDR_WATCHDOG_CONTROL_REG, `RSI_RST_WATCHDOG_CONTROL_REG, DIRTY, 4'hF);
		addRow(`RSI_ADDR_TBC, `RSI_RST_TBC, DIRTY, 4'hF);
		for (int a = 4; a < 7; a++) addRow(5'(a), 8'h00, DIRTY, 4'hF);
		addRow(`RSI_ADDR_PA, `RSI_RST_ONES, DIRTY, 4'hF);
		addRow(`RSI_ADDR_PAC, `RSI_RST_ONES, DIRTY, 4'hF);
		addRow(`RSI_ADDR_PORT_A_PULLUP, `RSI_RST_ZERO, DIRTY, 4'hF);
		addRow(`RSI_ADDR_PORT_A_WAKEUP, `RSI_RST_ZERO, DIRTY, 4'hF);
		addRow(`RSI_ADDR_MP0, DIRTY | 8'h80, DIRTY | 8'h80, 4'hE);
		addRow(`RSI_ADDR_MP1, DIRTY | 8'h80, DIRTY | 8'h80, 4'hE);
		for (int a = 13; a < 16; a++) addRow(5'(a), DIRTY, DIRTY, 4'hE);
		addRow(`RSI_ADDR_PCL, 8'h00, 8'h00, 4'hF);
		addRow(`RSI_ADDR_EEA, 8'h00, 8'h00, 4'h8);
		addRow(`RSI_ADDR_SERIAL_IFACE_CTRL0, `RSI_RST_SERIAL_IFACE_CTRL0, DIRTY & `RSI_SERIAL_IFACE_CTRL0_MASK, 4'hF);
		addRow(`RSI_ADDR_SERIAL_IFACE_CTRL1, `RSI_RST_SERIAL_IFACE_CTRL1, DIRTY, 4'hF);
		addRow(`RSI_ADDR_ACERL, `RSI_RST_ONES, DIRTY, 4'hF);
		for (int t = 0; t < `RSI_NUM_TM; t++) addRow(5'(`RSI_ADDR_TMBASE + t), 8'h00, DIRTY, 4'hF);
		repeat (3) @(posedge mclk);
		chk("rst pcl", programCounterLow_r, 0);
		chk("rst sp", stackPointer_r, `RSI_RST_TOP_STACK);
		chk("rst flags", {timeoutFlag_r, powerdownFlag_r}, 0);
		chk("rst pac", portADirection_r, `RSI_RST_ONES);
		chk("rst analog", analogInputs_r, `RSI_RST_ONES);
		chk("rst count", watchdogCount_r, 0);
		resetn <= 1'b1;
		for (int c = 0; c < 5; c++) begin
			foreach (rows[i]) wrReg(rows[i].addr, DIRTY);
			pulse(6'h20, 1'b0);
			if (preLow[c]) pulse(6'h10, 1'b0);
			pulse(causeMask[c], c == 4);
			chk("timeout", timeoutFlag_r, expTo[c]);
			chk("powerdown", powerdownFlag_r, expPdf[c]);
			chk("pcl", programCounterLow_r, 0);
			chk("count", watchdogCount_r, 0);
			if (grp[c] == 0) chk("sp", stackPointer_r, `RSI_RST_TOP_STACK);
			if (grp[c] == 3) chk("sp", stackPointer_r, 0);
			chk("pac", portADirection_r, grp[c] == 3 ? DIRTY : 8'hFF);
			chk("analog", analogInputs_r, grp[c] == 3 ? DIRTY : 8'hFF);
			@(negedge mclk);
			chk("counting", watchdogCount_r != 0, 1);
			rdReg(`RSI_ADDR_STATUS, rd);
			chk("status", rd, {2'b00, expTo[c], expPdf[c], 4'h0});
			foreach (rows[i]) begin
				if (rows[i].care[grp[c]]) begin
					rdReg(rows[i].addr, rd);
					chk("reg", rd, rows[i].exp[grp[c]]);
				end
			end
		end
		// write in the cycle of a pin reset is lost
		@(posedge mclk);
		externalClearPin <= 1'b1;
		regAddr <= `RSI_ADDR_SYSTEM_MODE_REG;
		regWdata <= 8'h55;
		regWr <= 1'b1;
		@(posedge mclk);
		externalClearPin <= 1'b0;
		regWr <= 1'b0;
		rdReg(`RSI_ADDR_SYSTEM_MODE_REG, rd);
		chk("lost write", rd, `RSI_RST_SYSTEM_MODE_REG);
		// power-on wins over a simultaneous idle watchdog
		pulse(6'h08, 1'b1);
		pulse(6'h09, 1'b1);
		chk("prio flags", {timeoutFlag_r, powerdownFlag_r}, 0);
		chk("prio sp", stackPointer_r, `RSI_RST_TOP_STACK);
		// clear instruction drops both flags
		pulse(6'h08, 1'b1);
		pulse(6'h20, 1'b0);
		chk("clr flags", {timeoutFlag_r, powerdownFlag_r}, 0);
		chk("clr count", watchdogCount_r, 0);
		// back-to-back reads, unmapped then status
		pulse(6'h08, 1'b0);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= 5'h15;
		@(posedge mclk);
		regAddr <= `RSI_ADDR_STATUS;
		@(negedge mclk);
		chk("unmapped", regRdata, 0);
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		chk("b2b status", regRdata, 8'h20);
		// reset in mid-run
		wrReg(`RSI_ADDR_PAC, DIRTY);
		@(posedge mclk);
		resetn <= 1'b0;
		@(negedge mclk);
		chk("mid pac", portADirection_r, `RSI_RST_ONES);
		chk("mid flags", {timeoutFlag_r, powerdownFlag_r}, 0);
		chk("mid sp", stackPointer_r, `RSI_RST_TOP_STACK);
		chk("mid rdata", regRdata, 0);
		@(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk("post count", watchdogCount_r, 2);
		finalReport();
	end
endmodule // rsi_reset_init_tb
